/* File: essp_policy.sv */
// Enclave shadow-stack policy: access checks, page operations, entry and exit state
//
`timescale 1ns/1ps
module essp_policy
#(
  parameter int SECTIONS = 2,
  parameter int CFP_W    = 64
)
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Section query
  input  wire logic                   query_valid,
  input  wire logic [31:0]            query_subleaf,
  input  wire logic [SECTIONS*52-1:0] sect_base,
  input  wire logic [SECTIONS*52-1:0] sect_size,
  input  wire logic [SECTIONS*4-1:0]  sect_prot,
  output logic                        result_valid,
  output logic [31:0]                 first_output_word,
  output logic [31:0]                 second_output_word,
  output logic [31:0]                 third_output_word,
  output logic [31:0]                 fourth_output_word,
  // Enclave range
  input  wire logic [63:0]            range_base,
  input  wire logic [63:0]            range_limit,
  // Memory access check
  input  wire logic                   acc_valid,
  input  wire logic                   acc_in_enclave,
  input  wire logic                   acc_leaf_init,
  input  wire essp_pkg::essp_access_type acc_kind,
  input  wire logic [63:0]            acc_addr,
  input  wire logic                   acc_translates_protected,
  input  wire essp_pkg::essp_page_type acc_page_type,
  input  wire logic [63:0]            acc_rdata,
  output logic                        chk_valid,
  output logic                        chk_fault,
  output logic                        chk_drop_write,
  output logic [63:0]                 chk_rdata,
  output essp_pkg::essp_class_type    chk_class,
  // Branch-target marker miss
  input  wire logic                   marker_miss,
  input  wire logic [63:0]            marker_addr,
  output logic                        bitmap_valid,
  output logic [51:0]                 bitmap_index,
  // Page operations
  input  wire logic                   op_valid,
  input  wire essp_pkg::essp_op_type  op_kind,
  input  wire essp_pkg::essp_page_type op_page_type,
  input  wire logic [63:0]            op_page_addr,
  input  wire logic                   op_param_present,
  input  wire logic                   op_perm_rw,
  input  wire logic                   op_content_zero,
  input  wire logic [63:0]            op_token,
  input  wire logic [63:0]            op_saved_ptr,
  output logic                        op_done,
  output logic                        op_reject,
  output essp_pkg::essp_page_type     op_result_type,
  output logic                        token_write,
  output logic [63:0]                 token_addr,
  output logic [63:0]                 token_data,
  // Mode transitions
  input  wire logic                   tr_valid,
  input  wire essp_pkg::essp_trans_type tr_kind,
  input  wire logic [CFP_W-1:0]       host_cfp,
  input  wire logic [CFP_W-1:0]       enclave_cfp_in,
  input  wire logic [63:0]            thr_saved_ptr,
  input  wire logic [63:0]            cur_ssp,
  output logic                        in_enclave,
  output logic                        tr_reject,
  output logic [CFP_W-1:0]            active_cfp,
  output logic [63:0]                 ssp_out,
  output logic                        thr_ptr_write,
  output logic [63:0]                 thr_ptr_data,
  output logic                        frame_write,
  output logic [CFP_W-1:0]            frame_data
);
  import essp_pkg::*;

  // Refuse unusable widths
  if (CFP_W < 1)
    $error("CFP_W must be positive");

  // Address inside the protected linear range
  function automatic logic in_range(input logic [63:0] a);
    return (a >= range_base) && (a <= range_limit);
  endfunction

  // Page at either end of the range
  function automatic logic at_range_edge(input logic [63:0] a);
    return (a[63:PAGE_SHIFT] == range_base[63:PAGE_SHIFT]) ||
           (a[63:PAGE_SHIFT] == range_limit[63:PAGE_SHIFT]);
  endfunction

  function automatic logic is_shadow(input essp_page_type t);
    return (t == essp_pt_sh_first) || (t == essp_pt_sh_rest);
  endfunction

  // Section report lives in its own module
  essp_section_query #(.SECTIONS(SECTIONS)) u_query
  (
    .clk                (clk),
    .rst                (rst),
    .query_valid        (query_valid),
    .query_subleaf      (query_subleaf),
    .sect_base          (sect_base),
    .sect_size          (sect_size),
    .sect_prot          (sect_prot),
    .result_valid       (result_valid),
    .first_output_word  (first_output_word),
    .second_output_word (second_output_word),
    .third_output_word  (third_output_word),
    .fourth_output_word (fourth_output_word)
  );

  // Access classification and permission check
  logic           next_fault;
  logic           next_drop;
  logic [63:0]    next_rdata;
  essp_class_type next_class;
  logic           a_in_range;
  logic           is_ss;

  always_comb
  begin
    a_in_range = in_range(acc_addr);
    is_ss      = (acc_kind == essp_acc_ss_load) || (acc_kind == essp_acc_ss_store);
    next_fault = 1'b0;
    next_drop  = 1'b0;
    next_rdata = acc_rdata;
    if (acc_in_enclave && a_in_range)
      next_class = essp_cls_direct;
    else if (acc_leaf_init)
      next_class = essp_cls_leaf;
    else
      next_class = essp_cls_non_enclave;
    if (acc_in_enclave)
    begin
      if (is_ss && !a_in_range)
        next_fault = 1'b1;
      if (a_in_range && !acc_translates_protected)
        next_fault = 1'b1;
      if (a_in_range && is_shadow(acc_page_type) && acc_kind == essp_acc_store)
        next_fault = 1'b1;
      if (a_in_range && is_ss && !is_shadow(acc_page_type))
        next_fault = 1'b1;
    end
    else if (!acc_leaf_init && acc_translates_protected)
    begin
      // Secrecy over usefulness: reads see all ones, writes vanish
      next_rdata = 64'hffff_ffff_ffff_ffff;
      next_drop  = (acc_kind == essp_acc_store) || (acc_kind == essp_acc_ss_store);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      chk_valid      <= 1'b0;
      chk_fault      <= 1'b0;
      chk_drop_write <= 1'b0;
      chk_rdata      <= 64'h0;
      chk_class      <= essp_cls_non_enclave;
    end
    else
    begin
      chk_valid <= acc_valid;
      if (acc_valid)
      begin
        chk_fault      <= next_fault;
        chk_drop_write <= next_drop;
        chk_rdata      <= next_rdata;
        chk_class      <= next_class;
      end
    end
  end

  // Legacy bitmap index from the page offset inside the range
  logic [63:0] marker_off;
  assign marker_off = marker_addr - range_base;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bitmap_valid <= 1'b0;
      bitmap_index <= 52'h0;
    end
    else
    begin
      bitmap_valid <= marker_miss && in_enclave;
      if (marker_miss)
        bitmap_index <= in_enclave ? marker_off[63:PAGE_SHIFT]
                                   : marker_addr[63:PAGE_SHIFT];
    end
  end

  // Page operation checks
  logic          next_reject;
  essp_page_type next_type;
  logic          token_ok;

  always_comb
  begin
    next_reject = 1'b0;
    next_type   = op_page_type;
    token_ok    = (op_token == op_page_addr + PAGE_BYTES);
    case (op_kind)
      essp_op_static_add:
      begin
        if (is_shadow(op_page_type) && at_range_edge(op_page_addr))
          next_reject = 1'b1;
        if (op_page_type == essp_pt_sh_rest && !op_content_zero)
          next_reject = 1'b1;
        // Zero check here excludes the token bytes
        if (op_page_type == essp_pt_sh_first && (!op_content_zero || !token_ok))
          next_reject = 1'b1;
        if (op_page_type == essp_pt_thr && op_saved_ptr != 64'h0)
          next_reject = 1'b1;
      end
      essp_op_dyn_alloc:
      begin
        if (!op_param_present)
          next_type = essp_pt_reg;
        else if (is_shadow(op_page_type) && !op_perm_rw)
          next_reject = 1'b1;
        if (op_param_present && is_shadow(op_page_type) && at_range_edge(op_page_addr))
          next_reject = 1'b1;
      end
      essp_op_accept:
      begin
        if (op_page_type == essp_pt_thr && op_saved_ptr != 64'h0)
          next_reject = 1'b1;
      end
      essp_op_accept_copy, essp_op_restrict, essp_op_extend:
      begin
        if (is_shadow(op_page_type))
          next_reject = 1'b1;
      end
      default:
      begin
        next_reject = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      op_done        <= 1'b0;
      op_reject      <= 1'b0;
      op_result_type <= essp_pt_reg;
      token_write    <= 1'b0;
      token_addr     <= 64'h0;
      token_data     <= 64'h0;
    end
    else
    begin
      op_done     <= op_valid;
      token_write <= 1'b0;
      if (op_valid)
      begin
        op_reject      <= next_reject;
        op_result_type <= next_type;
        if (op_kind == essp_op_dyn_alloc && !next_reject && next_type == essp_pt_sh_first)
        begin
          token_write <= 1'b1;
          token_addr  <= {op_page_addr[63:PAGE_SHIFT], TOKEN_OFFSET};
          token_data  <= op_page_addr + PAGE_BYTES;
        end
      end
    end
  end

  // Entry and exit: host scratchpad, enclave state, shadow pointer
  logic [CFP_W-1:0] host_scratch;
  logic             next_tr_ok;

  always_comb
  begin
    case (tr_kind)
      essp_tr_enter, essp_tr_resume:
        next_tr_ok = !in_enclave;
      essp_tr_exit, essp_tr_async_exit:
        next_tr_ok = in_enclave;
      default:
        next_tr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      in_enclave    <= 1'b0;
      tr_reject     <= 1'b0;
      host_scratch  <= '0;
      active_cfp    <= '0;
      ssp_out       <= 64'h0;
      thr_ptr_write <= 1'b0;
      thr_ptr_data  <= 64'h0;
      frame_write   <= 1'b0;
      frame_data    <= '0;
    end
    else
    begin
      tr_reject     <= tr_valid && !next_tr_ok;
      thr_ptr_write <= 1'b0;
      frame_write   <= 1'b0;
      if (tr_valid && next_tr_ok)
      begin
        if (tr_kind == essp_tr_enter || tr_kind == essp_tr_resume)
        begin
          in_enclave   <= 1'b1;
          host_scratch <= host_cfp;
          active_cfp   <= enclave_cfp_in;
          ssp_out      <= thr_saved_ptr;
        end
        else
        begin
          in_enclave    <= 1'b0;
          active_cfp    <= host_scratch;
          thr_ptr_write <= 1'b1;
          thr_ptr_data  <= cur_ssp;
          if (tr_kind == essp_tr_async_exit)
          begin
            frame_write <= 1'b1;
            frame_data  <= active_cfp;
          end
        end
      end
    end
  end

endmodule

/* File: essp_pkg.sv */
// Shared constants and types for the enclave shadow-stack policy block
package essp_pkg;

  // Section query word layout
  localparam int TYPE_LSB     = 0;
  localparam int TYPE_MSB     = 3;
  localparam int ADDR_LO_LSB  = 12;
  localparam int ADDR_LO_MSB  = 31;
  localparam int ADDR_HI_LSB  = 32;
  localparam int ADDR_HI_MSB  = 51;
  localparam int HI_FIELD_W   = 20;
  localparam logic [3:0] SECT_INVALID  = 4'h0;
  localparam logic [3:0] SECT_VALID    = 4'h1;
  localparam logic [3:0] PROT_NONE     = 4'h0;
  localparam logic [3:0] PROT_CONF_INT = 4'h1;
  localparam logic [3:0] PROT_CONF     = 4'h2;
  localparam int FIRST_SECT_LEAF = 2;

  // Page geometry
  localparam int PAGE_SHIFT            = 12;
  localparam logic [63:0] PAGE_BYTES   = 64'h0000_0000_0000_1000;
  localparam logic [11:0] TOKEN_OFFSET = 12'hff8;
  localparam int TOKEN_BYTES           = 8;

  // Page types held in the page map
  typedef enum logic [2:0] {
    essp_pt_reg,
    essp_pt_thr,
    essp_pt_sh_first,
    essp_pt_sh_rest,
    essp_pt_other
  } essp_page_type;

  // Access kinds
  typedef enum logic [2:0] {
    essp_acc_load,
    essp_acc_store,
    essp_acc_ss_load,
    essp_acc_ss_store,
    essp_acc_fetch
  } essp_access_type;

  // Page operations
  typedef enum logic [2:0] {
    essp_op_none,
    essp_op_static_add,
    essp_op_dyn_alloc,
    essp_op_accept,
    essp_op_accept_copy,
    essp_op_restrict,
    essp_op_extend
  } essp_op_type;

  // Access classification
  typedef enum logic [1:0] {
    essp_cls_non_enclave,
    essp_cls_direct,
    essp_cls_leaf
  } essp_class_type;

  // Mode transitions
  typedef enum logic [2:0] {
    essp_tr_none,
    essp_tr_enter,
    essp_tr_resume,
    essp_tr_exit,
    essp_tr_async_exit,
    essp_tr_other
  } essp_trans_type;

endpackage

/* File: essp_section_query.sv */
// Protected page-cache section report for the identification query
`timescale 1ns/1ps
module essp_section_query
#(
  parameter int SECTIONS = 2
)
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 query_valid,
  input  wire logic [31:0]          query_subleaf,
  input  wire logic [SECTIONS*52-1:0] sect_base,
  input  wire logic [SECTIONS*52-1:0] sect_size,
  input  wire logic [SECTIONS*4-1:0]  sect_prot,
  output logic                      result_valid,
  output logic [31:0]               first_output_word,
  output logic [31:0]               second_output_word,
  output logic [31:0]               third_output_word,
  output logic [31:0]               fourth_output_word
);
  import essp_pkg::*;

  // Refuse unusable section counts
  if (SECTIONS < 1 || SECTIONS > 64)
    $error("SECTIONS out of range");

  logic [31:0] idx;
  logic        hit;
  logic [51:0] base;
  logic [51:0] size;
  logic [3:0]  prot;

  // Select the section named by the sub-leaf
  always_comb
  begin
    idx  = query_subleaf - 32'(FIRST_SECT_LEAF);
    hit  = (query_subleaf >= 32'(FIRST_SECT_LEAF)) && (idx < 32'(SECTIONS));
    base = '0;
    size = '0;
    prot = PROT_NONE;
    for (int i = 0; i < SECTIONS; i++)
    begin
      if (hit && idx == 32'(i))
      begin
        base = sect_base[i*52 +: 52];
        size = sect_size[i*52 +: 52];
        prot = sect_prot[i*4 +: 4];
      end
    end
  end

  // Registered result words; reserved fields forced to zero
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      result_valid       <= 1'b0;
      first_output_word  <= 32'h0;
      second_output_word <= 32'h0;
      third_output_word  <= 32'h0;
      fourth_output_word <= 32'h0;
    end
    else
    begin
      result_valid <= query_valid;
      if (query_valid)
      begin
        if (!hit)
        begin
          first_output_word  <= 32'h0;
          second_output_word <= 32'h0;
          third_output_word  <= 32'h0;
          fourth_output_word <= 32'h0;
        end
        else
        begin
          first_output_word  <= {base[ADDR_LO_MSB:ADDR_LO_LSB], 8'h00, SECT_VALID};
          second_output_word <= {12'h000, base[ADDR_HI_MSB:ADDR_HI_LSB]};
          // Unknown protection codes are reported as none: pair is then all zero
          if (prot == PROT_CONF_INT || prot == PROT_CONF)
          begin
            third_output_word  <= {size[ADDR_LO_MSB:ADDR_LO_LSB], 8'h00, prot};
            fourth_output_word <= {12'h000, size[ADDR_HI_MSB:ADDR_HI_LSB]};
          end
          else
          begin
            third_output_word  <= 32'h0;
            fourth_output_word <= 32'h0;
          end
        end
      end
    end
  end

endmodule

/* File: essp_far_model.sv */
// Far-side model: firmware section layout and enclave linear range seen by the block
`timescale 1ns/1ps
module essp_far_model
(
  output logic [4*52-1:0] sect_base,
  output logic [4*52-1:0] sect_size,
  output logic [4*4-1:0]  sect_prot,
  output logic [63:0]     range_base,
  output logic [63:0]     range_limit
);
  // Four reserved sections; low bits carry junk so the reported words must mask them
  assign sect_base = {52'ha_bcde_f123_4fff, 52'h1_2345_6789_a000,
                      52'h5_0000_0000_1000, 52'hf_ffff_ffff_ffff};
  assign sect_size = {52'h0_0010_0000_0abc, 52'h0_0002_8000_0000,
                      52'h3_0000_0800_0000, 52'h0_0001_fff0_0fff};
  // Codes: integrity, confidentiality only, none, reserved
  assign sect_prot = {4'h3, 4'h0, 4'h2, 4'h1};
  // Sixteen pages; shadow pages inside are mapped writable at both table levels
  assign range_base  = 64'h0000_0000_0001_0000;
  assign range_limit = 64'h0000_0000_0001_ffff;
endmodule

/* File: essp_policy_assertions.sv */
// Concurrent checks on the policy block's ports
`timescale 1ns/1ps
module essp_policy_checker
#(
  parameter int SECTIONS = 2
)
(
  input wire logic                      clk,
  input wire logic                      rst,
  input wire logic                      query_valid,
  input wire logic [31:0]               query_subleaf,
  input wire logic                      result_valid,
  input wire logic [31:0]               first_output_word,
  input wire logic [31:0]               second_output_word,
  input wire logic [31:0]               third_output_word,
  input wire logic [31:0]               fourth_output_word,
  input wire logic [63:0]               range_base,
  input wire logic [63:0]               range_limit,
  input wire logic                      acc_valid,
  input wire logic                      acc_in_enclave,
  input wire logic                      acc_leaf_init,
  input wire essp_pkg::essp_access_type acc_kind,
  input wire logic [63:0]               acc_addr,
  input wire logic                      acc_translates_protected,
  input wire essp_pkg::essp_page_type   acc_page_type,
  input wire logic                      chk_valid,
  input wire logic                      chk_fault,
  input wire logic [63:0]               chk_rdata,
  input wire logic                      tr_valid,
  input wire essp_pkg::essp_trans_type  tr_kind,
  input wire logic [63:0]               cur_ssp,
  input wire logic                      in_enclave,
  input wire logic                      tr_reject,
  input wire logic                      thr_ptr_write,
  input wire logic [63:0]               thr_ptr_data
);
  import essp_pkg::*;
  // Range test and direct-access qualifier shared by the in-enclave access checks
  wire logic in_rng = (acc_addr >= range_base) && (acc_addr <= range_limit);
  wire logic direct = acc_valid && acc_in_enclave && !acc_leaf_init;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_invalid_zero: assert property (
    query_valid && query_subleaf >= 32'(SECTIONS + 2) |=> result_valid && {first_output_word,
    second_output_word, third_output_word, fourth_output_word} == 128'h0)
    else $error("invalid sub-leaf words not zero");
  a_reserved_zero: assert property (
    result_valid |-> first_output_word[11:4] == 8'h00 && second_output_word[31:20] == 12'h000
    && third_output_word[11:4] == 8'h00 && fourth_output_word[31:20] == 12'h000)
    else $error("reserved query bits set");
  a_ss_store_refused: assert property (
    direct && in_rng && acc_translates_protected && acc_kind == essp_acc_store
    && acc_page_type inside {essp_pt_sh_first, essp_pt_sh_rest} |=> chk_valid && chk_fault)
    else $error("ordinary store to shadow page allowed");
  a_ss_in_range: assert property (
    direct && !in_rng && acc_kind inside {essp_acc_ss_load, essp_acc_ss_store} |=> chk_fault)
    else $error("shadow access outside range allowed");
  a_untranslated_fault: assert property (
    direct && in_rng && !acc_translates_protected |=> chk_valid && chk_fault)
    else $error("untranslated range address not faulted");
  a_outside_read_ones: assert property (
    acc_valid && !acc_in_enclave && !acc_leaf_init && acc_translates_protected
    && acc_kind == essp_acc_load |=> chk_rdata == 64'hffff_ffff_ffff_ffff)
    else $error("outside read of protected page not masked");
  a_other_refused: assert property (
    tr_valid && tr_kind == essp_tr_other |=> tr_reject && in_enclave == $past(in_enclave))
    else $error("improper transition accepted");
  a_exit_saves_ptr: assert property (
    tr_valid && tr_kind == essp_tr_exit && in_enclave
    |=> thr_ptr_write && thr_ptr_data == $past(cur_ssp))
    else $error("shadow pointer not saved on exit");
endmodule

bind essp_policy essp_policy_checker #(.SECTIONS(SECTIONS)) essp_policy_checker_inst (.*);

/* File: tb_enclave_shadow_stack_policy.sv */
// Directed testbench for the enclave shadow-stack policy block
`timescale 1ns/1ps
module tb_enclave_shadow_stack_policy;
  import essp_pkg::*;
  localparam int NS = 4;
  logic clk, rst, query_valid, result_valid, acc_valid, acc_in_enclave, acc_leaf_init;
  logic acc_translates_protected, chk_valid, chk_fault, chk_drop_write, marker_miss;
  logic bitmap_valid, op_valid, op_param_present, op_perm_rw, op_content_zero, op_done;
  logic op_reject, token_write, tr_valid, in_enclave, tr_reject, thr_ptr_write, frame_write;
  logic [31:0] query_subleaf, first_output_word, second_output_word, third_output_word;
  logic [31:0] fourth_output_word;
  logic [51:0] bitmap_index;
  logic [NS*52-1:0] sect_base, sect_size;
  logic [NS*4-1:0] sect_prot;
  logic [63:0] range_base, range_limit, acc_addr, acc_rdata, chk_rdata, marker_addr;
  logic [63:0] op_page_addr, op_token, op_saved_ptr, token_addr, token_data, host_cfp;
  logic [63:0] enclave_cfp_in, thr_saved_ptr, cur_ssp, active_cfp, ssp_out, thr_ptr_data;
  logic [63:0] frame_data;
  essp_access_type acc_kind;
  essp_page_type acc_page_type, op_page_type, op_result_type;
  essp_op_type op_kind;
  essp_class_type chk_class;
  essp_trans_type tr_kind;
  int num_errors = 0;
  int n_compared = 0;

  essp_far_model essp_far_model_inst (.sect_base(sect_base), .sect_size(sect_size),
    .sect_prot(sect_prot), .range_base(range_base), .range_limit(range_limit));
  essp_policy #(.SECTIONS(NS)) essp_policy_inst (.*);

  // Free-running core clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic finish_test;
    if (num_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmp(input string n, input logic [63:0] e, input logic [63:0] g);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Section query; expected words rebuilt from the far model's layout
  task automatic query(input int s);
    logic [51:0] b;
    logic [51:0] z;
    logic [3:0] p;
    logic ok;
    logic pv;
    @(posedge clk);
    query_valid <= 1'b1;
    query_subleaf <= 32'(s);
    @(posedge clk);
    query_valid <= 1'b0;
    #1;
    ok = (s >= 2) && (s < NS + 2);
    b = '0;
    z = '0;
    p = '0;
    if (ok)
    begin
      b = sect_base[(s-2)*52 +: 52];
      z = sect_size[(s-2)*52 +: 52];
      p = sect_prot[(s-2)*4 +: 4];
    end
    pv = ok && (p == PROT_CONF_INT || p == PROT_CONF);
    cmp("result_valid", 1, result_valid);
    cmp("word0", ok ? {b[31:12], 8'h00, SECT_VALID} : 0, first_output_word);
    cmp("word1", ok ? {12'h000, b[51:32]} : 0, second_output_word);
    cmp("word2", pv ? {z[31:12], 8'h00, p} : 0, third_output_word);
    cmp("word3", pv ? {12'h000, z[51:32]} : 0, fourth_output_word);
  endtask

  task automatic acc(input logic ie, input essp_access_type k, input logic [63:0] a,
                     input logic tp, input essp_page_type pt, input logic ef,
                     input essp_class_type ec);
    @(posedge clk);
    acc_valid <= 1'b1;
    acc_in_enclave <= ie;
    acc_kind <= k;
    acc_addr <= a;
    acc_translates_protected <= tp;
    acc_page_type <= pt;
    @(posedge clk);
    acc_valid <= 1'b0;
    #1;
    cmp("chk_valid", 1, chk_valid);
    cmp("chk_fault", ef, chk_fault);
    cmp("chk_class", ec, chk_class);
  endtask

  // Page operation; prz packs parameter present, read/write, content zero
  task automatic op(input essp_op_type k, input essp_page_type pt, input logic [63:0] a,
                    input logic [2:0] prz, input logic [63:0] tk, input logic [63:0] sp,
                    input logic er);
    @(posedge clk);
    op_valid <= 1'b1;
    op_kind <= k;
    op_page_type <= pt;
    op_page_addr <= a;
    {op_param_present, op_perm_rw, op_content_zero} <= prz;
    op_token <= tk;
    op_saved_ptr <= sp;
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
    cmp("op_done", 1, op_done);
    cmp("op_reject", er, op_reject);
  endtask

  task automatic tr(input essp_trans_type k, input logic er, input logic ei);
    @(posedge clk);
    tr_valid <= 1'b1;
    tr_kind <= k;
    @(posedge clk);
    tr_valid <= 1'b0;
    #1;
    cmp("tr_reject", er, tr_reject);
    cmp("in_enclave", ei, in_enclave);
  endtask

  // Watchdog: whole sequence needs under a hundred cycles
  initial
  begin
    #20000;
    num_errors++;
    finish_test();
  end

  // Main sequence
  initial
  begin
    rst = 1'b1;
    {query_valid, acc_valid, acc_in_enclave, acc_leaf_init, acc_translates_protected} = '0;
    {marker_miss, op_valid, op_param_present, op_perm_rw, op_content_zero, tr_valid} = '0;
    query_subleaf = '0;
    {acc_addr, marker_addr, op_page_addr, op_token, op_saved_ptr} = '0;
    acc_kind = essp_acc_load;
    acc_page_type = essp_pt_reg;
    op_page_type = essp_pt_reg;
    op_kind = essp_op_none;
    tr_kind = essp_tr_none;
    acc_rdata = 64'h0123_4567_89ab_cdef;
    host_cfp = 64'h1111_2222_3333_4444;
    enclave_cfp_in = 64'h5555_6666_7777_8888;
    thr_saved_ptr = 64'h0000_0000_0001_fff8;
    cur_ssp = 64'h0000_0000_0001_ef00;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 2; i < NS + 3; i++) query(i);
    query(-1);
    tr(essp_tr_exit, 1, 0);
    tr(essp_tr_other, 1, 0);
    tr(essp_tr_enter, 0, 1);
    cmp("active_cfp", enclave_cfp_in, active_cfp);
    cmp("ssp_out", thr_saved_ptr, ssp_out);
    tr(essp_tr_resume, 1, 1);
    @(posedge clk);
    marker_miss <= 1'b1;
    marker_addr <= 64'h0000_0000_0001_3456;
    @(posedge clk);
    marker_miss <= 1'b0;
    #1;
    cmp("bitmap_valid", 1, bitmap_valid);
    cmp("bitmap_index", 52'h3, bitmap_index);
    acc(1, essp_acc_store, 64'h12000, 1, essp_pt_sh_first, 1, essp_cls_direct);
    acc(1, essp_acc_load, 64'h13008, 1, essp_pt_sh_rest, 0, essp_cls_direct);
    acc(1, essp_acc_ss_store, 64'h12ff8, 1, essp_pt_sh_first, 0, essp_cls_direct);
    acc(1, essp_acc_ss_load, 64'h20000, 0, essp_pt_reg, 1, essp_cls_non_enclave);
    acc(1, essp_acc_load, 64'h14000, 0, essp_pt_reg, 1, essp_cls_direct);
    acc(0, essp_acc_load, 64'h14000, 1, essp_pt_reg, 0, essp_cls_non_enclave);
    cmp("chk_rdata", 64'hffff_ffff_ffff_ffff, chk_rdata);
    acc(0, essp_acc_store, 64'h14000, 1, essp_pt_reg, 0, essp_cls_non_enclave);
    cmp("chk_drop_write", 1, chk_drop_write);
    acc_leaf_init <= 1'b1;
    acc(0, essp_acc_load, 64'h14000, 1, essp_pt_reg, 0, essp_cls_leaf);
    cmp("chk_rdata", acc_rdata, chk_rdata);
    acc_leaf_init <= 1'b0;
    tr(essp_tr_async_exit, 0, 0);
    cmp("active_cfp", host_cfp, active_cfp);
    cmp("thr_ptr_write", 1, thr_ptr_write);
    cmp("thr_ptr_data", cur_ssp, thr_ptr_data);
    cmp("frame_write", 1, frame_write);
    cmp("frame_data", enclave_cfp_in, frame_data);
    tr(essp_tr_resume, 0, 1);
    cmp("ssp_out", thr_saved_ptr, ssp_out);
    cur_ssp <= 64'h0000_0000_0001_e000;
    tr(essp_tr_exit, 0, 0);
    cmp("thr_ptr_data", 64'h1_e000, thr_ptr_data);
    cmp("frame_write", 0, frame_write);
    cmp("active_cfp", host_cfp, active_cfp);
    op(essp_op_dyn_alloc, essp_pt_sh_first, 64'h12000, 3'b111, 0, 0, 0);
    cmp("op_result_type", essp_pt_sh_first, op_result_type);
    cmp("token_write", 1, token_write);
    cmp("token_addr", 64'h12000 | 64'(TOKEN_OFFSET), token_addr);
    cmp("token_data", 64'h12000 + PAGE_BYTES, token_data);
    op(essp_op_dyn_alloc, essp_pt_sh_first, 64'h12000, 3'b011, 0, 0, 0);
    cmp("op_result_type", essp_pt_reg, op_result_type);
    cmp("token_write", 0, token_write);
    op(essp_op_dyn_alloc, essp_pt_sh_rest, 64'h10000, 3'b111, 0, 0, 1);
    op(essp_op_static_add, essp_pt_sh_rest, 64'h1f000, 3'b111, 0, 0, 1);
    op(essp_op_static_add, essp_pt_sh_rest, 64'h15000, 3'b110, 0, 0, 1);
    op(essp_op_static_add, essp_pt_sh_rest, 64'h15000, 3'b111, 0, 0, 0);
    op(essp_op_static_add, essp_pt_sh_first, 64'h16000, 3'b111, 64'h17000, 0, 0);
    op(essp_op_static_add, essp_pt_sh_first, 64'h16000, 3'b111, 64'h16ff8, 0, 1);
    op(essp_op_static_add, essp_pt_thr, 64'h18000, 3'b111, 0, 64'h40, 1);
    op(essp_op_accept, essp_pt_thr, 64'h18000, 3'b111, 0, 64'h8, 1);
    op(essp_op_accept, essp_pt_thr, 64'h18000, 3'b111, 0, 0, 0);
    for (int i = 4; i < 7; i++)
      op(essp_op_type'(i), essp_pt_sh_rest, 64'h15000, 3'b111, 0, 0, 1);
    finish_test();
  end
endmodule
